// ==== verilog/mifd_cfg_top.sv ====
/*
  interrupt-mode, masking and fan divisor configuration of a hardware monitor:
  second mask register, second status register (hot, fan, overtemperature
  bits), fan divisor / shared pin register, tachometer prescalers and the
  shared reset / overtemperature open-drain pin.
  assumes the serial management front end hands over decoded register
  accesses as one-cycle strobes on MCLK, and that the conversion datapath
  delivers comparison results and a conversion-done pulse on MCLK.
*/
`timescale 1ns/1ps
`include "mifd_cfg.svh"

module mifd_cfg_top (
  input wire logic MCLK,               // 40 MHz monitor clock
  input wire logic RST_N,              // async reset, active low
  input wire logic [7:0] REG_ADDR,     // register address
  input wire logic REG_WR,             // write strobe, one cycle
  input wire logic REG_RD,             // read strobe, one cycle
  input wire logic [7:0] REG_WDATA,    // write data
  output logic [7:0] REG_RDATA,        // read data, valid cycle after strobe
  input wire logic CONV_DONE,          // conversion completed, one cycle
  input wire logic HOT_ABOVE,          // temperature above hot limit
  input wire logic HOT_BELOW,          // temperature below hot hysteresis
  input wire logic OT_ABOVE,           // temperature above overtemp limit
  input wire logic OT_BELOW,           // temperature below overtemp hysteresis
  input wire logic FAN_A_LIMIT,        // first fan count limit exceeded, pulse
  input wire logic FAN_B_LIMIT,        // second fan count limit exceeded, pulse
  input wire logic TACH_INPUT_A,       // first fan pin, asynchronous
  input wire logic TACH_INPUT_B,       // second fan pin, asynchronous
  input wire logic [3:0] VOLTAGE_ID_INPUTS, // voltage id straps, asynchronous
  input wire logic RST_OUT_REQ,        // reset pulse request from monitor logic
  output logic INT_N,                  // interrupt output, active low
  output logic TACH_TICK_A,            // prescaled first fan edge, pulse
  output logic TACH_TICK_B,            // prescaled second fan edge, pulse
  output logic SHARED_PIN_OUT,         // shared pin level when driven
  output logic SHARED_PIN_OE,          // shared pin pulled low while high
  output logic [1:0] SHARED_PIN_MODE   // 0 off, 1 overtemp, 2 reset
);

  logic [7:0] mask2_q, mask2_d;
  logic [7:0] stat2_q, stat2_d;
  logic [7:0] fandiv_q, fandiv_d;
  logic [7:0] rdata_q, rdata_d;
  logic int_n_q, int_n_d;
  logic [3:0] vid_lvl;
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic strap_done_q, strap_done_d;
  logic pin_oe_q, pin_oe_d;
  mifd_pkg::mifd_pin_e pin_mode_q, pin_mode_d;
  logic [1:0] fan_set;
  logic [1:0] fan_tick;
  logic [1:0] temp_set;
  logic [1:0] tach_pin;
  logic [1:0] fan_limit;
  logic [1:0] cmp_above;
  logic [1:0] cmp_below;
  logic [1:0] temp_mode;
  logic stat_rd;
  logic [7:0] set_vec;

  assign tach_pin = {TACH_INPUT_B, TACH_INPUT_A};
  assign fan_limit = {FAN_B_LIMIT, FAN_A_LIMIT};
  assign cmp_above = {OT_ABOVE, HOT_ABOVE};
  assign cmp_below = {OT_BELOW, HOT_BELOW};
  assign temp_mode = {mask2_q[`MIFD_B_OT_MODE], mask2_q[`MIFD_B_HOT_MODE]};
  assign stat_rd = REG_RD && (REG_ADDR == `MIFD_ADDR_STAT2);

  // voltage id straps: three-flop synchroniser and agree filter per bit
  for (genvar v = 0; v < 4; v++) begin : g_vid
    logic [2:0] sync_q, sync_d;
    logic lvl_q, lvl_d;

    // shift the strap in; level follows once second and third stage agree
    always_comb begin
      sync_d = {sync_q[1:0], VOLTAGE_ID_INPUTS[v]};
      lvl_d = lvl_q;
      if (sync_q[1] == sync_q[2]) begin
        lvl_d = sync_q[2];
      end
    end

    // strap synchroniser and filter flip-flops
    always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
        sync_q <= 3'h0;
        lvl_q <= 1'b0;
      end else begin
        sync_q <= sync_d;
        lvl_q <= lvl_d;
      end
    end

    // next filtered value, so a load on the fourth edge sees the settled strap
    assign vid_lvl[v] = lvl_d;
  end

  // tachometer inputs: synchroniser, level filter, mode and prescaler
  for (genvar f = 0; f < 2; f++) begin : g_fan
    logic [2:0] sync_q, sync_d;
    logic lvl_q, lvl_d;
    logic [2:0] edge_q, edge_d;
    logic tick_q, tick_d;
    logic level_mode;
    logic [2:0] wrap;
    mifd_pkg::mifd_div_t div;

    assign level_mode = fandiv_q[`MIFD_B_MODE_A + f];
    assign div = fandiv_q[`MIFD_B_DIV_A + 2 * f +: 2];

    // next sync, filtered level, edge count and tick
    always_comb begin
      sync_d = {sync_q[1:0], tach_pin[f]};
      lvl_d = lvl_q;
      edge_d = edge_q;
      tick_d = 1'b0;
      unique case (div)
        2'h0: wrap = 3'h0;
        2'h1: wrap = 3'h1;
        2'h2: wrap = 3'h3;
        2'h3: wrap = 3'h7;
      endcase
      // change counts once second and third stage agree
      if (sync_q[1] == sync_q[2]) begin
        lvl_d = sync_q[2];
      end
      // count mode: one tick per 1, 2, 4 or 8 rising edges
      if (!level_mode && lvl_d && !lvl_q) begin
        if (edge_q >= wrap) begin
          edge_d = 3'h0;
          tick_d = 1'b1;
        end else begin
          edge_d = edge_q + 3'h1;
        end
      end
      if (level_mode) begin
        edge_d = 3'h0;
      end
    end

    // fan synchroniser, filter, counter and tick flip-flops
    always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
        sync_q <= 3'h0;
        lvl_q <= 1'b0;
        edge_q <= 3'h0;
        tick_q <= 1'b0;
      end else begin
        sync_q <= sync_d;
        lvl_q <= lvl_d;
        edge_q <= edge_d;
        tick_q <= tick_d;
      end
    end

    // level mode: active low when polarity bit set, else active high
    assign fan_set[f] = level_mode ? (lvl_q ^ fandiv_q[`MIFD_B_LVL_POL])
                                   : fan_limit[f];
    assign fan_tick[f] = tick_q;
  end

  // temperature channels: 0 hot, 1 overtemperature
  for (genvar t = 0; t < 2; t++) begin : g_temp
    logic alarm_q, alarm_d;

    // alarm region entered above limit, left below hysteresis
    always_comb begin
      alarm_d = alarm_q;
      if (CONV_DONE) begin
        if (!alarm_q && cmp_above[t]) begin
          alarm_d = 1'b1;
        end else if (alarm_q && cmp_below[t]) begin
          alarm_d = 1'b0;
        end
      end
    end

    // alarm region flip-flop
    always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
        alarm_q <= 1'b0;
      end else begin
        alarm_q <= alarm_d;
      end
    end

    // default: every conversion inside alarm; one-time: on crossings only
    assign temp_set[t] = CONV_DONE && (temp_mode[t] ? (alarm_d != alarm_q)
                                                    : alarm_d);
  end

  assign set_vec = {2'b00, temp_set[1], 1'b0, fan_set[1], fan_set[0], 1'b0, temp_set[0]};

  // next status, interrupt and read data
  always_comb begin
    stat2_d = stat2_q;
    if (stat_rd) begin
      stat2_d = `MIFD_STAT2_RST;
    end
    stat2_d = (stat2_d | set_vec) & `MIFD_STAT2_IMPL; // set wins over read clear
    int_n_d = ~|(stat2_q & ~mask2_q);
    rdata_d = rdata_q;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `MIFD_ADDR_STAT2: rdata_d = stat2_q;
        `MIFD_ADDR_FANDIV: rdata_d = fandiv_q;
        `MIFD_ADDR_MASK2: rdata_d = mask2_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // next shared pin use and drive; reset mode wins when both bits are set
  always_comb begin
    if (fandiv_q[`MIFD_B_RST_EN]) begin
      pin_mode_d = mifd_pkg::PIN_RESET;
      pin_oe_d = RST_OUT_REQ;
    end else if (fandiv_q[`MIFD_B_OS_EN]) begin
      pin_mode_d = mifd_pkg::PIN_OVERTEMP;
      pin_oe_d = stat2_q[`MIFD_B_OT];
    end else begin
      pin_mode_d = mifd_pkg::PIN_OFF;
      pin_oe_d = 1'b0;
    end
  end

  // shared pin flip-flops, pin released during reset
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_oe_q <= 1'b0;
      pin_mode_q <= mifd_pkg::PIN_OFF;
    end else begin
      pin_oe_q <= pin_oe_d;
      pin_mode_q <= pin_mode_d;
    end
  end

  // next writable registers and strap capture
  always_comb begin
    mask2_d = mask2_q;
    fandiv_d = fandiv_q;
    strap_cnt_d = strap_cnt_q;
    strap_done_d = strap_done_q;
    if (!strap_done_q) begin
      if (strap_cnt_q == `MIFD_STRAP_WAIT) begin
        fandiv_d[3:0] = vid_lvl;
        strap_done_d = 1'b1;
      end else begin
        strap_cnt_d = strap_cnt_q + 2'h1;
      end
    end
    if (REG_WR && (REG_ADDR == `MIFD_ADDR_MASK2)) begin
      mask2_d = REG_WDATA;
    end
    if (REG_WR && (REG_ADDR == `MIFD_ADDR_FANDIV)) begin
      fandiv_d = REG_WDATA;
      strap_done_d = 1'b1; // software value is not overwritten by straps
    end
  end

  // register everything
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mask2_q <= `MIFD_MASK2_RST;
      stat2_q <= `MIFD_STAT2_RST;
      fandiv_q <= {`MIFD_FANDIV_HI_RST, `MIFD_FANDIV_LO_RST};
      rdata_q <= 8'h00;
      int_n_q <= 1'b1;
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else begin
      mask2_q <= mask2_d;
      stat2_q <= stat2_d;
      fandiv_q <= fandiv_d;
      rdata_q <= rdata_d;
      int_n_q <= int_n_d;
      strap_cnt_q <= strap_cnt_d;
      strap_done_q <= strap_done_d;
    end
  end

  // outputs straight from flip-flops, except the shared pin level, which is tied low
  assign REG_RDATA = rdata_q;
  assign INT_N = int_n_q;
  assign TACH_TICK_A = fan_tick[0];
  assign TACH_TICK_B = fan_tick[1];
  assign SHARED_PIN_OUT = 1'b0; // open drain: only ever pulls low
  assign SHARED_PIN_OE = pin_oe_q;
  assign SHARED_PIN_MODE = pin_mode_q;

endmodule

// ==== shared/mifd_cfg.svh ====
/*
  register offsets, field positions, reset values and timing counts of the
  monitor interrupt-mode and fan divisor configuration block.
  assumes it is included by bare name wherever these values are needed.
*/
`ifndef MIFD_CFG_SVH
`define MIFD_CFG_SVH

// register offsets on the serial management register port
`define MIFD_ADDR_STAT2 8'h02
`define MIFD_ADDR_FANDIV 8'h05
`define MIFD_ADDR_MASK2 8'h44

// reset values
`define MIFD_MASK2_RST 8'h00
`define MIFD_STAT2_RST 8'h00
`define MIFD_FANDIV_HI_RST 4'h5
`define MIFD_FANDIV_LO_RST 4'h0

// second status and mask register fields
`define MIFD_B_HOT 0
`define MIFD_B_FAN_A 2
`define MIFD_B_FAN_B 3
`define MIFD_B_OT 5
`define MIFD_B_HOT_MODE 6
`define MIFD_B_OT_MODE 7
`define MIFD_STAT2_IMPL 8'h2d

// fan divisor register fields
`define MIFD_B_MODE_A 0
`define MIFD_B_LVL_POL 2
`define MIFD_B_DIV_A 2
`define MIFD_B_OS_EN 6
`define MIFD_B_RST_EN 7

// cycles after reset release before the voltage id straps are captured
`define MIFD_STRAP_WAIT 2'h3

`endif

// ==== shared/mifd_pkg.sv ====
/*
  types of the monitor interrupt-mode and fan divisor configuration block.
  assumes nothing of its surroundings.
*/
package mifd_pkg;

  // use of the shared reset / overtemperature output pin
  typedef enum logic [1:0] {
    PIN_OFF,
    PIN_OVERTEMP,
    PIN_RESET
  } mifd_pin_e;

  // prescaler setting of one tachometer input
  typedef logic [1:0] mifd_div_t;

endpackage

// ==== dv/mifd_cfg_assertions.sv ====
/* concurrent checks of the interrupt-mode and fan divisor block.
   assumes the bench binds it to the top module. */
`timescale 1ns/1ps
module mifd_cfg_assertions (
  input wire logic MCLK, // clock
  input wire logic RST_N, // reset, active low
  input wire logic [7:0] REG_ADDR, // address
  input wire logic REG_WR, // write strobe
  input wire logic REG_RD, // read strobe
  input wire logic [7:0] REG_WDATA, // write data
  input wire logic [7:0] REG_RDATA, // read data
  input wire logic RST_OUT_REQ, // reset request
  input wire logic INT_N, // interrupt
  input wire logic TACH_TICK_A, // fan tick
  input wire logic SHARED_PIN_OUT, // pin level
  input wire logic SHARED_PIN_OE, // pin enable
  input wire logic [1:0] SHARED_PIN_MODE // pin mode
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  // register access shapes
  sequence s_mask_wr_rd;
    REG_WR && REG_ADDR == 8'h44 ##2 REG_RD && REG_ADDR == 8'h44;
  endsequence
  sequence s_div_wr;
    REG_WR && REG_ADDR == 8'h05;
  endsequence
  a_mask_read_back: assert property (s_mask_wr_rd |=> REG_RDATA == $past(REG_WDATA, 3))
    else $error("mask read back differs");
  a_pin_mode_sel: assert property (s_div_wr |=> ##1 SHARED_PIN_MODE ==
    ($past(REG_WDATA[7], 2) ? 2'h2 : {1'b0, $past(REG_WDATA[6], 2)}))
    else $error("pin mode wrong");
  a_pin_off_idle: assert property ((SHARED_PIN_MODE == 2'h0) [*2] |-> !SHARED_PIN_OE)
    else $error("pin driven while off");
  a_reset_follow: assert property ((SHARED_PIN_MODE == 2'h2) [*2] |->
    SHARED_PIN_OE == $past(RST_OUT_REQ)) else $error("reset pin wrong");
  a_open_drain: assert property (SHARED_PIN_OUT == 1'b0)
    else $error("pin driven high");
  a_mask_all_quiet: assert property (REG_WR && REG_ADDR == 8'h44 &&
    REG_WDATA == 8'hff |=> ##1 INT_N) else $error("masked interrupt seen");
  a_unmapped_zero: assert property (REG_RD && !(REG_ADDR inside {8'h02, 8'h05, 8'h44})
    |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
  a_stat_reserved: assert property (REG_RD && REG_ADDR == 8'h02
    |=> (REG_RDATA & 8'hd2) == 8'h00) else $error("reserved status set");
  a_tick_single: assert property (TACH_TICK_A |=> !TACH_TICK_A)
    else $error("tick too long");
endmodule

// ==== dv/mifd_host.sv ====
/* host model: register accesses over the management port.
   assumes the device samples strobes on the rising clock. */
`timescale 1ns/1ps
module mifd_host (
  input wire logic clk, // clock
  output logic [7:0] addr, // address
  output logic wr, // write strobe
  output logic rd, // read strobe
  output logic [7:0] wdata, // write data
  input wire logic [7:0] rdata // read data
);
  // idle bus
  initial begin
    {addr, wr, rd, wdata} = '0;
  end
  // one access, data taken the cycle after the strobe
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk);
    #2;
    {addr, wdata, wr, rd} = {a, d, w, !w};
    @(posedge clk);
    #2;
    {wr, rd} = 2'h0;
    q = rdata;
  endtask
endmodule

// ==== dv/mifd_cfg_top_tb.sv ====
/* bench: masks, status modes, fan prescalers and levels, shared pin.
   assumes host model and checker are compiled first. */
`timescale 1ns/1ps
module mifd_cfg_top_tb;
  logic MCLK, RST_N, w, r, cd, fla, flb, ta, rq, int_n, tka, tkb, po, poe;
  logic [7:0] a, wd, rdq, q, b;
  logic [3:0] voltage_id_inputs, cv;
  logic [1:0] pm;
  integer num_errors, cmp_count, seed, na, nb, i, k, s;
  mifd_host host (.clk(MCLK), .addr(a), .wr(w), .rd(r), .wdata(wd), .rdata(rdq));
  mifd_cfg_top DUT (.MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(a), .REG_WR(w), .REG_RD(r),
    .REG_WDATA(wd), .REG_RDATA(rdq), .CONV_DONE(cd), .HOT_ABOVE(cv[3]), .HOT_BELOW(cv[2]),
    .OT_ABOVE(cv[1]), .OT_BELOW(cv[0]), .FAN_A_LIMIT(fla), .FAN_B_LIMIT(flb),
    .TACH_INPUT_A(ta), .TACH_INPUT_B(ta), .VOLTAGE_ID_INPUTS(voltage_id_inputs), .RST_OUT_REQ(rq),
    .INT_N(int_n), .TACH_TICK_A(tka), .TACH_TICK_B(tkb), .SHARED_PIN_OUT(po),
    .SHARED_PIN_OE(poe), .SHARED_PIN_MODE(pm));
  // clock
  initial begin
    MCLK = 0;
    forever #12.5 MCLK = ~MCLK;
  end
  // tick counters
  always @(posedge MCLK) begin
    na <= na + tka;
    nb <= nb + tkb;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #2;
  endtask
  task rd(input logic [7:0] ad, input logic [7:0] e);
    host.acc(1'b0, ad, 8'h00, q);
    chk(q, e);
  endtask
  task wr(input logic [7:0] ad, input logic [7:0] d);
    host.acc(1'b1, ad, d, q);
  endtask
  task conv(input logic [3:0] t);
    cyc(1);
    cv = t;
    cd = 1;
    cyc(1);
    cd = 0;
    cyc(2);
  endtask
  // expected status per step: above, above, below, below, above
  function logic [7:0] ex(input logic m, input int s, input logic [7:0] b);
    return (((m ? 5'b10101 : 5'b11001) >> (4 - s)) & 5'h1) ? b : 8'h00;
  endfunction
  task end_of_test;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    cyc(20000);
    num_errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    {num_errors, cmp_count, na, nb} = '0;
    seed = 7;
    voltage_id_inputs = 4'($random(seed));
    {RST_N, cd, cv, fla, flb, ta, rq} = '0;
    cyc(2);
    RST_N = 1;
    cyc(10);
    rd(8'h05, {4'h5, voltage_id_inputs});
    rd(8'h44, 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h7f, 8'hff);
    rd(8'h7f, 8'h00);
    rd(8'h05, 8'h00);
    for (i = 0; i < 5; i++) begin
      b = i ? 8'($random(seed)) : 8'hff;
      wr(8'h44, b);
      rd(8'h44, b);
    end
    $display("registers done");
    for (k = 0; k < 4; k++) begin
      b = k[1] ? 8'h20 : 8'h01;
      wr(8'h44, {k[1] & k[0], !k[1] & k[0], k[1] & k[0], 5'h0});
      conv(4'b0101);
      host.acc(1'b0, 8'h02, 8'h00, q);
      for (s = 0; s < 5; s++) begin
        conv((s == 2 || s == 3) ? 4'b0101 : (k[1] ? 4'b0010 : 4'b1000));
        if (s == 0) chk({7'h0, int_n}, {7'h0, k == 3});
        rd(8'h02, ex(k[0], s, b));
      end
    end
    $display("modes done");
    wr(8'h44, 8'h00);
    fla = 1;
    flb = 1;
    cyc(1);
    {fla, flb} = 2'h0;
    rd(8'h02, 8'h0c);
    for (i = 0; i < 4; i++) begin
      wr(8'h05, {2'h0, 2'(3 - i), 2'(i), 2'h0});
      {na, nb} = '0;
      repeat (16) begin
        ta = 1;
        cyc(4);
        ta = 0;
        cyc(4);
      end
      cyc(8);
      chk(8'(na), 8'(16 >> i));
      chk(8'(nb), 8'(2 << i));
    end
    for (i = 0; i < 4; i++) begin
      wr(8'h05, {5'h0, i[1], 2'h3});
      ta = i[0];
      cyc(8);
      host.acc(1'b0, 8'h02, 8'h00, q);
      rd(8'h02, (i[1] ^ i[0]) ? 8'h0c : 8'h00);
    end
    $display("fans done");
    wr(8'h05, 8'h00);
    host.acc(1'b0, 8'h02, 8'h00, q);
    for (i = 0; i < 4; i++) begin
      wr(8'h05, {2'(i), 6'h0});
      cyc(2);
      chk({6'h0, pm}, i[1] ? 8'h02 : 8'(i));
      rq = 1;
      cyc(2);
      chk({7'h0, poe}, {7'h0, i[1]});
      rq = 0;
      conv(4'b0010);
      cyc(1);
      chk({7'h0, poe}, {7'h0, i == 1});
      rd(8'h02, 8'h20);
    end
    $display("pin done");
    voltage_id_inputs = 4'($random(seed));
    RST_N = 0;
    cyc(2);
    RST_N = 1;
    cyc(10);
    rd(8'h05, {4'h5, voltage_id_inputs});
    rd(8'h44, 8'h00);
    $display("reset done");
    end_of_test();
  end
endmodule
bind mifd_cfg_top mifd_cfg_assertions u_chk (.MCLK, .RST_N, .REG_ADDR, .REG_WR, .REG_RD,
  .REG_WDATA, .REG_RDATA, .RST_OUT_REQ, .INT_N, .TACH_TICK_A, .SHARED_PIN_OUT,
  .SHARED_PIN_OE, .SHARED_PIN_MODE);
